// ---- design/rsa_arbiter.sv ----
// Run/stop arbiter: panel switch, run terminal, remote commands and power-up diagnosis.
`default_nettype none

// Functional notes
// - Panel switch at run means running, except in two-button relay mode.
// - Parameter picks one of sixteen inputs, one of the first eight with SIXTEEN_POINT set.
// - Asserted run terminal forces running state.
// - Terminal low: state follows panel switch, or the button latch in two-button mode.
// - Remote commands force running or stopped.
// - Power-up discards any remote command.
// - After power-up only local sources decide.
// - Remote run restores after remote stop.
// - Local stop-then-run overrides remote stop.
// - Self-diagnosis must pass before running.
module rsa_arbiter #(
  parameter logic SIXTEEN_POINT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic panel_switch_run,
  input wire logic [15:0] general_inputs,
  input wire logic diag_fault,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic running,
  output logic error_led
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [16:0] pin_meta;
  logic [16:0] pin_sync;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta <= 17'h0_0000;
      pin_sync <= 17'h0_0000;
    end else if (clk_en) begin
      pin_meta <= {panel_switch_run, general_inputs};
      pin_sync <= pin_meta;
    end
  end

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  rsa_pkg::rsa_config_t cfg;
  rsa_pkg::rsa_status_t status;
  logic two_button_mode_relay;
  logic wr_fire;
  logic rd_take;

  // A request is held one cycle with waitrequest high, then taken.
  assign rd_take = avs_read && avs_waitrequest;
  assign wr_fire = avs_write && !avs_waitrequest;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_readdata <= rsa_pkg::UNMAPPED_READ;
    end else if (clk_en && rd_take) begin
      unique case (avs_address)
        rsa_pkg::ADDR_CONFIG: avs_readdata <= {27'h000_0000, cfg};
        rsa_pkg::ADDR_STATUS: avs_readdata <= {26'h000_0000, status};
        rsa_pkg::ADDR_RELAY: avs_readdata <= {31'h0000_0000, two_button_mode_relay};
        default: avs_readdata <= rsa_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // With SIXTEEN_POINT set, only the first eight inputs can be picked.
  logic [3:0] next_sel;
  assign next_sel = SIXTEEN_POINT ?
    {1'b0, avs_writedata[rsa_pkg::CFG_SEL_LSB +: 3]} :
    avs_writedata[rsa_pkg::CFG_SEL_LSB +: 4];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg.sel <= rsa_pkg::CFG_SEL_RESET;
      cfg.enable <= rsa_pkg::CFG_ENABLE_RESET;
    end else if (clk_en && wr_fire && avs_address == rsa_pkg::ADDR_CONFIG) begin
      cfg.sel <= next_sel;
      cfg.enable <= avs_writedata[rsa_pkg::CFG_ENABLE_BIT];
    end
  end

  logic remote_run_cmd;
  logic remote_stop_cmd;
  logic remote_clear_cmd;
  logic relay_run_cmd;
  logic relay_stop_cmd;

  assign remote_run_cmd = wr_fire && avs_address == rsa_pkg::ADDR_REMOTE &&
    avs_writedata[rsa_pkg::REM_RUN_BIT];
  assign remote_stop_cmd = wr_fire && avs_address == rsa_pkg::ADDR_REMOTE &&
    avs_writedata[rsa_pkg::REM_STOP_BIT];
  assign remote_clear_cmd = wr_fire && avs_address == rsa_pkg::ADDR_REMOTE &&
    avs_writedata[rsa_pkg::REM_CLEAR_BIT];
  assign relay_run_cmd = wr_fire && avs_address == rsa_pkg::ADDR_RELAY &&
    avs_writedata[rsa_pkg::RLY_RUN_BIT];
  assign relay_stop_cmd = wr_fire && avs_address == rsa_pkg::ADDR_RELAY &&
    avs_writedata[rsa_pkg::RLY_STOP_BIT];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      two_button_mode_relay <= 1'b0;
    end else if (clk_en && wr_fire && avs_address == rsa_pkg::ADDR_RELAY) begin
      two_button_mode_relay <= avs_writedata[rsa_pkg::RLY_MODE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Local run sources
  // ------------------------------------------------------------
  logic button_latch;
  logic terminal_run;
  logic switch_run;
  logic local_run;
  logic local_run_q;

  // The user program pulses the forced relays; stop dominates.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      button_latch <= 1'b0;
    end else if (clk_en) begin
      if (!two_button_mode_relay || relay_stop_cmd) begin
        button_latch <= 1'b0;
      end else if (relay_run_cmd) begin
        button_latch <= 1'b1;
      end
    end
  end

  assign terminal_run = cfg.enable && pin_sync[cfg.sel];
  assign switch_run = two_button_mode_relay ? button_latch : pin_sync[16];
  assign local_run = terminal_run || switch_run;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      local_run_q <= 1'b0;
    end else if (clk_en) begin
      local_run_q <= local_run;
    end
  end

  // ------------------------------------------------------------
  // Remote override
  // ------------------------------------------------------------
  logic remote_active;
  logic remote_is_run;

  // Reset clears the override; a local stop-to-run edge also ends it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remote_active <= 1'b0;
      remote_is_run <= 1'b0;
    end else if (clk_en) begin
      if (remote_run_cmd || remote_stop_cmd) begin
        remote_active <= 1'b1;
        remote_is_run <= remote_run_cmd && !remote_stop_cmd;
      end else if (remote_clear_cmd || (local_run && !local_run_q)) begin
        remote_active <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Power-up self-diagnosis
  // ------------------------------------------------------------
  rsa_pkg::rsa_phase_t phase;
  logic [7:0] diag_count;
  logic bad_param;

  assign bad_param = SIXTEEN_POINT && cfg.sel[3];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase <= rsa_pkg::RSA_DIAG;
      diag_count <= 8'h00;
    end else if (clk_en) begin
      unique case (phase)
        rsa_pkg::RSA_DIAG: begin
          if (diag_fault || bad_param) begin
            phase <= rsa_pkg::RSA_FAULT;
          end else if (diag_count == rsa_pkg::DIAG_LAST) begin
            phase <= rsa_pkg::RSA_READY;
          end else begin
            diag_count <= diag_count + 8'h01;
          end
        end
        rsa_pkg::RSA_READY: phase <= rsa_pkg::RSA_READY;
        rsa_pkg::RSA_FAULT: phase <= rsa_pkg::RSA_FAULT;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic next_running;

  assign next_running = (phase == rsa_pkg::RSA_READY) &&
    (remote_active ? remote_is_run : local_run);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      running <= 1'b0;
      error_led <= 1'b0;
    end else if (clk_en) begin
      running <= next_running;
      error_led <= phase == rsa_pkg::RSA_FAULT;
    end
  end

  assign status.running = running;
  assign status.remote_active = remote_active;
  assign status.remote_is_run = remote_is_run;
  assign status.diag_error = error_led;
  assign status.diag_done = phase != rsa_pkg::RSA_DIAG;
  assign status.local_run = local_run;

endmodule // rsa_arbiter
`default_nettype wire

// ---- shared/rsa_pkg.sv ----
// Package with register map, field layout, reset values and timing for the run/stop arbiter.
`default_nettype none
package rsa_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_REMOTE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_RELAY = 4'hc;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_ENABLE_BIT = 4;
  localparam int REM_RUN_BIT = 0;
  localparam int REM_STOP_BIT = 1;
  localparam int REM_CLEAR_BIT = 2;
  localparam int RLY_MODE_BIT = 0;
  localparam int RLY_RUN_BIT = 1;
  localparam int RLY_STOP_BIT = 2;

  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam logic [3:0] CFG_SEL_RESET = 4'h0;
  localparam logic CFG_ENABLE_RESET = 1'b0;
  localparam int CLK_MHZ = 50;
  localparam int DIAG_TIME_NS = 1000;
  localparam int DIAG_CYCLES = (DIAG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] DIAG_LAST = 8'(DIAG_CYCLES - 1);
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic [3:0] sel;
  } rsa_config_t;

  typedef struct packed {
    logic local_run;
    logic diag_done;
    logic diag_error;
    logic remote_is_run;
    logic remote_active;
    logic running;
  } rsa_status_t;

  typedef enum logic [1:0] {
    RSA_DIAG,
    RSA_READY,
    RSA_FAULT
  } rsa_phase_t;

endpackage
`default_nettype wire

// ---- test/rsa_arbiter_monitor.sv ----
// Checker on the run/stop arbiter ports.
`default_nettype none
module rsa_arbiter_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic panel_switch_run,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic running,
  input wire logic error_led
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] up_cnt;
  always_ff @(posedge ref_clk) begin
    if (rst)
      up_cnt <= 7'h00;
    else if (up_cnt != 7'h7f)
      up_cnt <= up_cnt + 7'h01;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($fell(rst) |-> avs_waitrequest && !running)
    else $error("outputs not quiet after reset");
  a_diag_hold: assert property ($fell(rst) |-> !running [*8])
    else $error("running during diagnosis");
  a_fault_stop: assert property (error_led |-> !running)
    else $error("running with fault");
  a_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  a_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  a_remote_wo: assert property (!avs_waitrequest && $past(avs_read) &&
    $past(avs_address) == rsa_pkg::ADDR_REMOTE |-> avs_readdata == 32'h0)
    else $error("command register readable");
  a_switch_run: assert property ($rose(panel_switch_run) && up_cnt > 7'd55 &&
    !error_led |-> ##[2:4] running)
    else $error("switch to run ignored");
  c_run: cover property ($rose(running));
  c_fault: cover property ($rose(error_led));
  c_read: cover property (!avs_waitrequest && $past(avs_read));
endmodule // rsa_arbiter_monitor
bind rsa_arbiter rsa_arbiter_monitor u_mon (.ref_clk(ref_clk), .rst(rst),
  .panel_switch_run(panel_switch_run), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .running(running), .error_led(error_led));
`default_nettype wire

// ---- test/rsa_arbiter_tb.sv ----
// Self-checking bench for the run/stop arbiter.
`default_nettype none
module rsa_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst = 1'b1, sw = 1'b0, fault = 1'b0, rd = 1'b0, wr = 1'b0;
  logic en = 1'b1;
  logic pin_sw, wq, run, led;
  logic [15:0] term = 16'h0000, pins;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdq, q;
  int num_errors = 0, num_checks = 0;
  always #10 ref_clk = ~ref_clk;
  rsa_partner u_far (.ref_clk(ref_clk), .sw_want(sw), .term_want(term),
    .panel_switch_run(pin_sw), .general_inputs(pins));
  rsa_arbiter dut (.ref_clk(ref_clk), .rst(rst), .clk_en(en), .panel_switch_run(pin_sw),
    .general_inputs(pins), .diag_fault(fault), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdq), .avs_waitrequest(wq),
    .running(run), .error_led(led));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk);
    end while (wq !== 1'b0);
    q = rdq;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic pwr(input logic f);
    rst <= 1'b1;
    fault <= f;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (60) @(posedge ref_clk);
    fault <= 1'b0;
  endtask
  task automatic see(input logic s, input logic [15:0] t, input logic e);
    sw <= s;
    term <= t;
    repeat (6) @(posedge ref_clk);
    chk(32'(run), 32'(e));
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    pwr(1'b0);
    bus(1'b0, rsa_pkg::ADDR_CONFIG, 32'h0);
    chk(q, {27'h0, rsa_pkg::CFG_ENABLE_RESET, rsa_pkg::CFG_SEL_RESET});
    bus(1'b1, rsa_pkg::ADDR_CONFIG, 32'h15);
    bus(1'b0, rsa_pkg::ADDR_CONFIG, 32'h0);
    chk(q, 32'h15);
    see(1'b1, 16'h0000, 1'b1);
    see(1'b0, 16'h0000, 1'b0);
    see(1'b0, 16'h0040, 1'b0);
    see(1'b0, 16'h0020, 1'b1);
    see(1'b1, 16'h0020, 1'b1);
    see(1'b1, 16'h0000, 1'b1);
    bus(1'b1, rsa_pkg::ADDR_REMOTE, 32'h2);
    see(1'b1, 16'h0000, 1'b0);
    bus(1'b1, rsa_pkg::ADDR_REMOTE, 32'h1);
    see(1'b1, 16'h0000, 1'b1);
    bus(1'b1, rsa_pkg::ADDR_REMOTE, 32'h2);
    see(1'b0, 16'h0000, 1'b0);
    see(1'b1, 16'h0000, 1'b1);
    bus(1'b1, rsa_pkg::ADDR_REMOTE, 32'h2);
    see(1'b0, 16'h0000, 1'b0);
    see(1'b0, 16'h0020, 1'b1);
    see(1'b0, 16'h0000, 1'b0);
    bus(1'b1, rsa_pkg::ADDR_REMOTE, 32'h1);
    see(1'b0, 16'h0000, 1'b1);
    bus(1'b0, rsa_pkg::ADDR_STATUS, 32'h0);
    chk(q & 32'h7, 32'h7);
    bus(1'b0, rsa_pkg::ADDR_REMOTE, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, rsa_pkg::UNMAPPED_READ);
    pwr(1'b0);
    chk(32'(run), 32'h0);
    see(1'b1, 16'h0000, 1'b1);
    en <= 1'b0;
    see(1'b0, 16'h0000, 1'b1);
    en <= 1'b1;
    see(1'b0, 16'h0000, 1'b0);
    bus(1'b1, rsa_pkg::ADDR_RELAY, 32'h1);
    bus(1'b1, rsa_pkg::ADDR_RELAY, 32'h3);
    see(1'b0, 16'h0000, 1'b1);
    bus(1'b1, rsa_pkg::ADDR_RELAY, 32'h5);
    see(1'b0, 16'h0000, 1'b0);
    bus(1'b1, rsa_pkg::ADDR_RELAY, 32'h0);
    pwr(1'b1);
    chk(32'(led), 32'h1);
    see(1'b1, 16'h0000, 1'b0);
    wrap_up;
  end
  initial begin
    #50000;
    num_errors++;
    wrap_up;
  end
endmodule // rsa_arbiter_tb
`default_nettype wire

// ---- test/rsa_partner.sv ----
// Model of the panel switch and the input terminals.
`default_nettype none
module rsa_partner (
  input wire logic ref_clk,
  input wire logic sw_want,
  input wire logic [15:0] term_want,
  output var logic panel_switch_run,
  output var logic [15:0] general_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    panel_switch_run = 1'b0;
    general_inputs = 16'h0000;
  end
  // The operator only sets levels; pins move just after a clock edge.
  always @(posedge ref_clk) begin
    panel_switch_run <= sw_want;
    general_inputs <= term_want;
  end
endmodule // rsa_partner
`default_nettype wire
